// ### hdl/ttc_control_regs.sv
`timescale 1ns/1ps
// How it works
// - Primary bit 0 high enables the tone output, burst or not.
// - Primary bit 1 picks tone mode (0) or call-progress detection (1).
// - Call-progress with interrupts on puts detected tones on the interrupt pin.
// - Call-progress plus burst doubles burst and pause to about 102 ms.
// - No received tone pair is decoded while call-progress is selected.
// - Tone mode with interrupts pulls the pin low on a validated tone.
// - Tone mode, interrupts and burst also pull the pin low on transmit ready.
// - Primary bit 3 sends only the next control write to the secondary register.
// - Burst mode makes each data write a fixed burst plus an equal pause.
// - After the pause transmit-empty status sets and an interrupt is raised.
// - Non-burst mode keeps tones on while enabled, with no timing.
// - Test mode shows inverted delayed steering on the interrupt pin.
// - Secondary bit 2 picks dual tones (0) or a single tone (1).
// - Single tone uses row group at bit 3 low, column group at high.
// - Select and read/write decode data write, data read, control, status.
// - Reading status clears interrupt, receive-full, transmit-empty and the request.
// - Transmit-ready sets 100 ms after a write, 204 ms when doubled.
module ttc_control_regs #(
   parameter longint BURST_CYCLES = ttc_pkg::BURST_CYC, // Burst length, tone mode
   parameter longint CP_BURST_CYCLES = ttc_pkg::CP_BURST_CYC // Burst length, call-progress
) (
   input wire logic clk, // 250 MHz clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic cs_n, // Chip select pin, active low
   input wire logic register_select_line, // Register select pin
   input wire logic rd_wr, // 1 read, 0 write
   input wire logic strobe, // Access strobe pin, access ends on falling edge
   input wire logic [3:0] data_in, // Data bus from host
   output logic [3:0] data_out, // Read data to host
   output logic data_oe, // Read data drive enable
   output logic [3:0] tx_code, // Latched transmit digit code
   output logic tone_gen_on, // Tone generator running
   output logic single_tone, // Single tone generation
   output logic column_group, // Single tone from column group
   output logic call_progress_select, // Call-progress filter path on
   output logic rx_decode_en, // Receive decoder allowed
   input wire logic [3:0] rx_code, // Decoded receive digit
   input wire logic rx_valid, // Valid tone pair persisted for guard time
   input wire logic delayed_steer, // Delayed steering from receiver
   input wire logic cp_tone, // Call-progress tone detected
   output logic interrupt_progress_pin_o, // Interrupt pin output level
   output logic interrupt_progress_pin_oe // Interrupt pin drive enable
);
   logic [2:0] cs_sync_r;
   logic [2:0] rs_sync_r;
   logic [2:0] rw_sync_r;
   logic [2:0] stb_sync_r;
   logic [3:0] d_sync1_r;
   logic [3:0] d_sync2_r;
   logic stb_last_r;
   logic [3:0] pc_r;
   logic [3:0] pc_nxt;
   logic [3:0] sc_r;
   logic [3:0] sc_nxt;
   logic [3:0] txd_r;
   logic [3:0] txd_nxt;
   logic [3:0] rxd_r;
   logic [3:0] rxd_nxt;
   logic to_second_r;
   logic to_second_nxt;
   logic st_irq_r;
   logic st_irq_nxt;
   logic st_txe_r;
   logic st_txe_nxt;
   logic st_rxf_r;
   logic st_rxf_nxt;
   logic rx_valid_last_r;
   ttc_pkg::ttc_tx_e tx_st_r;
   ttc_pkg::ttc_tx_e tx_st_nxt;
   logic [39:0] cnt_r;
   logic [39:0] cnt_nxt;
   logic [39:0] burst_len;
   logic access_end;
   logic [1:0] acc_kind;
   logic wr_data;
   logic wr_ctrl;
   logic rd_stat;
   logic rx_new;
   logic burst_mode;
   logic [3:0] stat_word;
   logic pin_low;
   logic [3:0] data_out_nxt;
   logic tone_gen_on_nxt;
   logic single_tone_nxt;
   logic column_group_nxt;
   logic call_progress_select_nxt;
   logic rx_decode_en_nxt;
   logic pin_oe_nxt;

   // Three-stage synchronisers for control pins, two-stage for data pins
   always_ff @(posedge clk) begin
      cs_sync_r <= {cs_sync_r[1:0], cs_n};
      rs_sync_r <= {rs_sync_r[1:0], register_select_line};
      rw_sync_r <= {rw_sync_r[1:0], rd_wr};
      stb_sync_r <= {stb_sync_r[1:0], strobe};
      d_sync1_r <= data_in;
      d_sync2_r <= d_sync1_r;
      stb_last_r <= stb_sync_r[2];
   end

   // Match of a finished access against one select and read/write pair
   function automatic logic is_access(input logic fire, input logic [1:0] seen,
                                      input logic [1:0] want);
      return fire && (seen == want);
   endfunction

   // Access decode at the end of the strobe
   always_comb begin
      access_end = stb_last_r && !stb_sync_r[2] && !cs_sync_r[2];
      acc_kind = {rs_sync_r[2], rw_sync_r[2]};
      wr_data = is_access(access_end, acc_kind, {ttc_pkg::SEL_DATA, 1'b0});
      wr_ctrl = is_access(access_end, acc_kind, {ttc_pkg::SEL_CTRL, 1'b0});
      rd_stat = is_access(access_end, acc_kind, {ttc_pkg::SEL_CTRL, 1'b1});
      burst_mode = !sc_r[ttc_pkg::SC_BURST_N];
      rx_new = rx_valid && !rx_valid_last_r && !pc_r[ttc_pkg::PC_CALL_PROG];
      burst_len = pc_r[ttc_pkg::PC_CALL_PROG] ? CP_BURST_CYCLES[39:0]
                                              : BURST_CYCLES[39:0];
   end

   // Control register and steering next values
   always_comb begin
      pc_nxt = pc_r;
      sc_nxt = sc_r;
      to_second_nxt = to_second_r;
      txd_nxt = txd_r;
      rxd_nxt = rxd_r;
      if (wr_ctrl) begin
         if (to_second_r) begin
            sc_nxt = d_sync2_r;
            to_second_nxt = 1'b0;
         end else begin
            pc_nxt = d_sync2_r;
            to_second_nxt = d_sync2_r[ttc_pkg::PC_SECOND_SEL];
         end
      end
      if (wr_data) begin
         txd_nxt = d_sync2_r;
      end
      if (rx_new) begin
         rxd_nxt = rx_code;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pc_r <= ttc_pkg::PC_RESET;
         sc_r <= ttc_pkg::SC_RESET;
         to_second_r <= 1'b0;
         txd_r <= 4'h0;
         rxd_r <= 4'h0;
         rx_valid_last_r <= 1'b0;
      end else begin
         pc_r <= pc_nxt;
         sc_r <= sc_nxt;
         to_second_r <= to_second_nxt;
         txd_r <= txd_nxt;
         rxd_r <= rxd_nxt;
         rx_valid_last_r <= rx_valid;
      end
   end

   // Burst sequencer: burst, equal pause, then ready
   always_comb begin
      tx_st_nxt = tx_st_r;
      cnt_nxt = cnt_r;
      if (!burst_mode) begin
         tx_st_nxt = ttc_pkg::TX_IDLE;
         cnt_nxt = 40'h0;
      end else if (wr_data) begin
         tx_st_nxt = ttc_pkg::TX_BURST;
         cnt_nxt = 40'h0;
      end else begin
         unique case (tx_st_r)
            ttc_pkg::TX_IDLE: begin
               cnt_nxt = 40'h0;
            end
            ttc_pkg::TX_BURST: begin
               cnt_nxt = cnt_r + 40'h1;
               if (cnt_r == burst_len - 40'h1) begin
                  tx_st_nxt = ttc_pkg::TX_PAUSE;
                  cnt_nxt = 40'h0;
               end
            end
            ttc_pkg::TX_PAUSE: begin
               cnt_nxt = cnt_r + 40'h1;
               if (cnt_r == burst_len - 40'h1) begin
                  tx_st_nxt = ttc_pkg::TX_IDLE;
                  cnt_nxt = 40'h0;
               end
            end
            default: begin
               tx_st_nxt = ttc_pkg::TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tx_st_r <= ttc_pkg::TX_IDLE;
         cnt_r <= 40'h0;
      end else begin
         tx_st_r <= tx_st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Status flags; a new event wins over the read clear
   always_comb begin
      st_txe_nxt = st_txe_r;
      st_rxf_nxt = st_rxf_r;
      st_irq_nxt = st_irq_r;
      if (rd_stat) begin
         st_txe_nxt = 1'b0;
         st_rxf_nxt = 1'b0;
         st_irq_nxt = 1'b0;
      end
      if (!burst_mode) begin
         st_txe_nxt = 1'b0;
      end else if (tx_st_r == ttc_pkg::TX_PAUSE && tx_st_nxt == ttc_pkg::TX_IDLE) begin
         st_txe_nxt = 1'b1;
         st_irq_nxt = 1'b1;
      end
      if (rx_new) begin
         st_rxf_nxt = 1'b1;
         st_irq_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_irq_r <= 1'b0;
         st_txe_r <= 1'b0;
         st_rxf_r <= 1'b0;
      end else begin
         st_irq_r <= st_irq_nxt;
         st_txe_r <= st_txe_nxt;
         st_rxf_r <= st_rxf_nxt;
      end
   end

   // Interrupt pin source selection
   always_comb begin
      if (sc_r[ttc_pkg::SC_TEST]) begin
         pin_low = delayed_steer;
      end else if (pc_r[ttc_pkg::PC_IRQ_EN] && pc_r[ttc_pkg::PC_CALL_PROG]) begin
         pin_low = !cp_tone;
      end else if (pc_r[ttc_pkg::PC_IRQ_EN]) begin
         pin_low = st_irq_r;
      end else begin
         pin_low = 1'b0;
      end
      stat_word = 4'h0;
      stat_word[ttc_pkg::ST_IRQ] = st_irq_r;
      stat_word[ttc_pkg::ST_TX_EMPTY] = st_txe_r;
      stat_word[ttc_pkg::ST_RX_FULL] = st_rxf_r;
      stat_word[ttc_pkg::ST_DSTEER] = !delayed_steer;
   end

   // Next values of the registered outputs
   always_comb begin
      data_out_nxt = rs_sync_r[2] ? stat_word : rxd_r;
      tone_gen_on_nxt = pc_r[ttc_pkg::PC_TONE_OUT] &&
                        (!burst_mode || tx_st_r == ttc_pkg::TX_BURST);
      single_tone_nxt = sc_r[ttc_pkg::SC_SINGLE];
      column_group_nxt = sc_r[ttc_pkg::SC_COLUMN];
      call_progress_select_nxt = pc_r[ttc_pkg::PC_CALL_PROG];
      rx_decode_en_nxt = !pc_r[ttc_pkg::PC_CALL_PROG];
      pin_oe_nxt = pin_low;
   end

   // Registered outputs to datapath and pins
   always_ff @(posedge clk) begin
      if (rst) begin
         data_out <= 4'h0;
         tx_code <= 4'h0;
         tone_gen_on <= 1'b0;
         single_tone <= 1'b0;
         column_group <= 1'b0;
         call_progress_select <= 1'b0;
         rx_decode_en <= 1'b0;
         interrupt_progress_pin_o <= 1'b0;
         interrupt_progress_pin_oe <= 1'b0;
      end else begin
         data_out <= data_out_nxt;
         tx_code <= txd_r;
         tone_gen_on <= tone_gen_on_nxt;
         single_tone <= single_tone_nxt;
         column_group <= column_group_nxt;
         call_progress_select <= call_progress_select_nxt;
         rx_decode_en <= rx_decode_en_nxt;
         interrupt_progress_pin_o <= 1'b0;
         interrupt_progress_pin_oe <= pin_oe_nxt;
      end
   end

   // Read data drive while a selected read has its strobe high
   assign data_oe = !cs_sync_r[2] && rw_sync_r[2] && stb_sync_r[2];

endmodule // ttc_control_regs

// ### hdl/ttc_pkg.sv
package ttc_pkg;
   // Register access decode on select and read/write lines
   localparam logic SEL_DATA = 1'b0;
   localparam logic SEL_CTRL = 1'b1;
   // Primary control field positions
   localparam int PC_TONE_OUT = 0;
   localparam int PC_CALL_PROG = 1;
   localparam int PC_IRQ_EN = 2;
   localparam int PC_SECOND_SEL = 3;
   // Secondary control field positions
   localparam int SC_BURST_N = 0;
   localparam int SC_TEST = 1;
   localparam int SC_SINGLE = 2;
   localparam int SC_COLUMN = 3;
   // Status field positions
   localparam int ST_IRQ = 0;
   localparam int ST_TX_EMPTY = 1;
   localparam int ST_RX_FULL = 2;
   localparam int ST_DSTEER = 3;
   // Reset values of the control registers
   localparam logic [3:0] PC_RESET = 4'h0;
   localparam logic [3:0] SC_RESET = 4'h0;
   // Burst timing
   localparam int CLK_MHZ = 250;
   localparam int BURST_MS = 50;
   localparam int CP_BURST_MS = 102;
   localparam longint BURST_CYC = longint'(BURST_MS) * 1000 * CLK_MHZ;
   localparam longint CP_BURST_CYC = longint'(CP_BURST_MS) * 1000 * CLK_MHZ;
   // Transmit sequencer states, Gray along idle-burst-pause
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_BURST = 2'b01,
      TX_PAUSE = 2'b11
   } ttc_tx_e;
endpackage : ttc_pkg

// ### sim/ttc_host.sv
`timescale 1ns/1ps
module ttc_host (
   input wire logic clk, // Bus clock
   output logic cs_n, // Chip select, active low
   output logic sel, // Register select line
   output logic rd_wr, // 1 read, 0 write
   output logic strobe, // Access strobe
   output logic [3:0] dq, // Write data
   input wire logic [3:0] q_in // Read data
);
   // Bus idle at time zero
   initial begin
      cs_n = 1'b1;
      sel = 1'b0;
      rd_wr = 1'b1;
      strobe = 1'b0;
      dq = 4'h0;
   end
   // One access, held from strobe rise to six clocks past its fall
   task automatic acc(input logic s, input logic r, input logic [3:0] d, output logic [3:0] q);
      @(negedge clk);
      cs_n = 1'b0;
      sel = s;
      rd_wr = r;
      dq = d;
      strobe = 1'b1;
      repeat (5) @(negedge clk);
      q = q_in;
      strobe = 1'b0;
      repeat (6) @(negedge clk);
      cs_n = 1'b1;
      dq = ~d; // Released bus shows no stale data
   endtask
endmodule // ttc_host

// ### sim/ttc_control_regs_asserts.sv
`timescale 1ns/1ps
module ttc_control_regs_asserts (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic cs_n, // Chip select
   input wire logic rd_wr, // Read/write
   input wire logic strobe, // Strobe
   input wire logic data_oe, // Read drive
   input wire logic [3:0] tx_code, // Transmit code
   input wire logic tone_gen_on, // Tone running
   input wire logic single_tone, // Single tone
   input wire logic column_group, // Column group
   input wire logic call_progress_select, // Call-progress path
   input wire logic rx_decode_en, // Decode allowed
   input wire logic interrupt_progress_pin_o // Pin level
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   // Access decode, control hold and burst shape
   no_decode_cp_a: assert property (call_progress_select |-> !rx_decode_en)
      else $error("decoder on in call-progress mode");
   wr_no_drive_a: assert property (!rd_wr [*5] |-> !data_oe)
      else $error("bus driven on write");
   cs_no_drive_a: assert property (cs_n [*5] |-> !data_oe)
      else $error("bus driven while deselected");
   rd_drive_a: assert property ((!cs_n && rd_wr && strobe) [*5] |-> data_oe)
      else $error("bus not driven on read");
   ctrl_hold_a: assert property (!strobe [*8] |->
      $stable({single_tone, column_group, call_progress_select}))
      else $error("control bit changed without write");
   tx_hold_a: assert property (!strobe [*8] |-> $stable(tx_code))
      else $error("transmit code changed without write");
   tone_start_a: assert property (!strobe [*8] |-> !$rose(tone_gen_on))
      else $error("tone started without write");
   burst_min_a: assert property ($rose(tone_gen_on) |-> tone_gen_on [*8])
      else $error("tone burst too short");
   pin_level_a: assert property (interrupt_progress_pin_o == 1'b0)
      else $error("interrupt pin driven high");
endmodule // ttc_control_regs_asserts
bind ttc_control_regs ttc_control_regs_asserts ttc_control_regs_asserts_inst (.clk, .rst,
   .cs_n, .rd_wr, .strobe, .data_oe, .tx_code, .tone_gen_on, .single_tone, .column_group,
   .call_progress_select, .rx_decode_en, .interrupt_progress_pin_o);

// ### sim/ttc_control_regs_tb.sv
`timescale 1ns/1ps
module ttc_control_regs_tb;
   localparam longint P = 10;
   logic clk, rst, cs_n, sel, rd_wr, strobe, data_oe, tone_gen_on, single_tone, column_group;
   logic call_progress_select, rx_decode_en, rx_valid, delayed_steer, cp_tone, pin_o, pin_oe;
   logic [3:0] data_in, data_out, tx_code, rx_code, q, v, pc;
   logic [7:0] rnd;
   int errors, n_checks, hi_n, last_hi, gap;
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ttc_control_regs #(.BURST_CYCLES(P), .CP_BURST_CYCLES(2 * P)) ttc_control_regs_inst (.clk,
      .rst, .cs_n, .register_select_line(sel), .rd_wr, .strobe, .data_in, .data_out, .data_oe,
      .tx_code, .tone_gen_on, .single_tone, .column_group, .call_progress_select, .rx_decode_en,
      .rx_code, .rx_valid, .delayed_steer, .cp_tone, .interrupt_progress_pin_o(pin_o),
      .interrupt_progress_pin_oe(pin_oe));
   ttc_host ttc_host_inst (.clk, .cs_n, .sel, .rd_wr, .strobe, .dq(data_in), .q_in(data_out));
   // Random source and expectations
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic exp_tone(input logic [3:0] p, input logic [3:0] s);
      return p[0] & s[0];
   endfunction
   // Comparison and bus shorthands
   task automatic ck(input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wc(input logic [3:0] d);
      ttc_host_inst.acc(1'b1, 1'b0, d, q);
   endtask
   task automatic wt(input logic [3:0] d);
      ttc_host_inst.acc(1'b0, 1'b0, d, q);
   endtask
   task automatic rd(input logic s);
      ttc_host_inst.acc(s, 1'b1, 4'h0, q);
   endtask
   task automatic wait_pin();
      for (int n = 0; n < 200 && pin_oe !== 1'b1; n++) @(negedge clk);
   endtask
   task automatic print_verdict();
      $display("errors=%0d checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Tone length and time from tone end
   always @(posedge clk) begin
      if (tone_gen_on === 1'b1) begin
         hi_n <= hi_n + 1;
         gap <= 0;
      end else begin
         if (hi_n != 0) last_hi <= hi_n;
         hi_n <= 0;
         gap <= gap + 1;
      end
   end
   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      print_verdict();
   end
   // Main sequence
   initial begin
      {rst, rx_code, rx_valid, delayed_steer, cp_tone} = 8'h80;
      {rnd, errors, n_checks, hi_n, last_hi, gap} = {8'h47, 160'h0};
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      rd(1'b1);
      wc(4'h0);
      wc(4'h0);
      wc(4'h8);
      wc(4'h0);
      rd(1'b1);
      ck(8'h0, {call_progress_select, single_tone, column_group, tone_gen_on});
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         v = {rnd[3:2], 1'b0, rnd[0]};
         pc = {1'b0, rnd[6:4]};
         wc(4'h8);
         wc(v);
         wc(pc);
         ck({v[3], v[2]}, {column_group, single_tone});
         ck(pc[1], call_progress_select);
         ck(!pc[1], rx_decode_en);
         ck(exp_tone(pc, v), tone_gen_on);
         ck(pc[2] & pc[1], pin_oe);
      end
      wc(4'h8);
      wc(4'h0);
      wc(4'h5);
      wt(rnd[3:0]);
      ck(rnd[3:0], tx_code);
      wait_pin();
      ck(8'(P), 8'(last_hi));
      ck(8'h1, {7'h0, gap >= P && gap <= P + 3});
      rd(1'b1);
      ck(2'h3, q[1:0]);
      ck(1'b0, pin_oe);
      rd(1'b1);
      ck(3'h0, q[2:0]);
      wc(4'h3);
      wt(rnd[7:4]);
      repeat (5 * P) @(negedge clk);
      ck(8'(2 * P), 8'(last_hi));
      rd(1'b1);
      ck(1'b1, q[1]);
      wc(4'h6);
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         cp_tone = rnd[0];
         rx_valid = rnd[1];
         repeat (3) @(negedge clk);
         ck(!cp_tone, pin_oe);
      end
      rd(1'b1);
      ck(1'b0, q[2]);
      {rx_valid, cp_tone, rx_code} = {2'b00, rnd[7:4]};
      wc(4'h4);
      rx_valid = 1'b1;
      wait_pin();
      ck(1'b1, pin_oe);
      rd(1'b0);
      ck(rx_code, q);
      rd(1'b1);
      ck(3'h5, q[2:0]);
      wc(4'h0);
      wc(4'h8);
      wc(4'h2);
      delayed_steer = 1'b1;
      repeat (3) @(negedge clk);
      ck(1'b1, pin_oe);
      delayed_steer = 1'b0;
      repeat (3) @(negedge clk);
      ck(1'b0, pin_oe);
      print_verdict();
   end
endmodule // ttc_control_regs_tb
